// ===== rtl/gx_expander.v
// 16-bit GPIO expander reached as a two-wire serial slave.
// Assumes open-drain bus lines resolved outside; the serial clock is
// sampled by clk, which must run well above the bus bit rate.
`timescale 1ns/100ps
`default_nettype none
`include "gx_map.vh"

module gx_expander #(
  parameter TOUT_CYC = (`GX_TOUT_US * 1000 + `GX_CLK_PERIOD_NS - 1)
    / `GX_CLK_PERIOD_NS,
  parameter TOUT_W = 22
) (
  input wire clk,
  input wire nrst,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe,
  input wire [1:0] addr_strap_0,
  input wire [1:0] addr_strap_1,
  input wire [1:0] addr_strap_2,
  input wire [15:0] port_pins_i,
  output wire [15:0] port_pins_o,
  output wire [15:0] port_pins_oe,
  output wire int_n_o,
  output reg int_n_oe
);

  // ****************************************
  // States and byte phases
  // ****************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX = 5'h02;
  localparam [4:0] ST_ACK = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_MACK = 5'h10;
  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_CMD = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;
  localparam [31:0] TOUT_LAST_W = TOUT_CYC - 1;
  localparam [TOUT_W-1:0] TOUT_LAST = TOUT_LAST_W[TOUT_W-1:0];

  // ****************************************
  // Pin synchronisation
  // ****************************************
  wire [23:0] sync_q;
  wire scl_s;
  wire sda_s;
  wire [15:0] pins_s;
  wire [1:0] strap0_s;
  wire [1:0] strap1_s;
  wire [1:0] strap2_s;

  gx_sync #(
    .W(24),
    .RST(24'hFFFFFF)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({addr_strap_2, addr_strap_1, addr_strap_0, port_pins_i,
      sda_i, scl_i}),
    .q(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign pins_s = sync_q[17:2];
  assign strap0_s = sync_q[19:18];
  assign strap1_s = sync_q[21:20];
  assign strap2_s = sync_q[23:22];

  // ****************************************
  // Bus edge and condition detection
  // ****************************************
  reg scl_d_q;
  reg sda_d_q;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  // Data moves only while clock is low, so any edge with clock high
  // is a bus condition, never a bit
  assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ****************************************
  // Slave address from straps
  // ****************************************
  // Each strap code: bit 1 set when tied to a bus line, bit 0 its level
  function [6:0] strap_addr;
    input [1:0] s2;
    input [1:0] s1;
    input [1:0] s0;
    begin
      strap_addr = {s2[`GX_STRAP_BUS_BIT], ~s1[`GX_STRAP_BUS_BIT],
        s1[`GX_STRAP_BUS_BIT], s0[`GX_STRAP_BUS_BIT],
        s2[`GX_STRAP_LVL_BIT], s1[`GX_STRAP_LVL_BIT],
        s0[`GX_STRAP_LVL_BIT]};
    end
  endfunction

  // Pair partner of a register; timeout and unknown codes stay put
  function [7:0] pair_of;
    input [7:0] p;
    begin
      if (p < `GX_OFS_TOUT) begin
        pair_of = p ^ 8'h01;
      end else begin
        pair_of = p;
      end
    end
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  // Writable registers live at index (offset - 2)
  reg [7:0] rf_q [0:6];
  reg [15:0] snap_q;
  reg [7:0] cmd_q;
  reg [7:0] ptr_q;
  reg [6:0] addr_q;
  wire [15:0] out_lvl;
  wire [15:0] inv;
  wire [15:0] dir;
  wire [15:0] in_view;
  wire tout_en;

  assign out_lvl = {rf_q[1], rf_q[0]};
  assign inv = {rf_q[3], rf_q[2]};
  assign dir = {rf_q[5], rf_q[4]};
  assign tout_en = rf_q[6][`GX_TOUT_EN_BIT];
  // Real pin levels, inverted only where the pin is an input
  assign in_view = pins_s ^ (inv & dir);

  function [7:0] reset_val;
    input [2:0] idx;
    begin
      if (idx < 3'd2) begin
        reset_val = `GX_RST_OUT;
      end else if (idx < 3'd4) begin
        reset_val = `GX_RST_INV;
      end else if (idx < 3'd6) begin
        reset_val = `GX_RST_DIR;
      end else begin
        reset_val = `GX_RST_TOUT;
      end
    end
  endfunction

  // Byte to send: first of a read uses the command, later ones the pointer
  reg [4:0] state_q;
  reg [7:0] tx_idx;
  reg [7:0] tx_byte;
  wire [7:0] tx_off;

  assign tx_off = tx_idx - 8'h02;

  always @* begin
    tx_idx = (state_q == ST_MACK) ? ptr_q : cmd_q;
    if (tx_idx == `GX_OFS_IN_LO) begin
      tx_byte = in_view[7:0];
    end else if (tx_idx == `GX_OFS_IN_HI) begin
      tx_byte = in_view[15:8];
    end else if (tx_idx <= `GX_OFS_TOUT) begin
      tx_byte = rf_q[tx_off[2:0]];
    end else begin
      tx_byte = 8'h00;
    end
  end

  // ****************************************
  // Serial state machine
  // ****************************************
  reg [1:0] phase_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg mack_q;
  reg [TOUT_W-1:0] tout_q;
  wire tout_hit;
  wire [7:0] wr_off;
  integer i;

  assign wr_off = ptr_q - 8'h02;
  assign sda_o = 1'b0;
  assign tout_hit = (tout_q == TOUT_LAST);

  // Bus-stuck watchdog; runs only inside a transfer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tout_q <= {TOUT_W{1'b0}};
    end else if (state_q == ST_IDLE || !tout_en || (scl_s & sda_s)
      || tout_hit) begin
      tout_q <= {TOUT_W{1'b0}};
    end else begin
      tout_q <= tout_q + 1'b1;
    end
  end

  // Straps are followed only while idle so an address never shifts
  // under a transfer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 7'h00;
    end else if (state_q == ST_IDLE) begin
      addr_q <= strap_addr(strap2_s, strap1_s, strap0_s);
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      mack_q <= 1'b0;
      sda_oe <= 1'b0;
      cmd_q <= 8'h00;
      ptr_q <= 8'h00;
      snap_q <= `GX_RST_SNAP;
      for (i = 0; i < 7; i = i + 1) begin
        rf_q[i] <= reset_val(i[2:0]);
      end
    end else if (tout_en && tout_hit) begin
      state_q <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_RX;
      phase_q <= PH_ADDR;
      bit_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (phase_q == PH_ADDR && sh_q[7:1] != addr_q) begin
              state_q <= ST_IDLE;
            end else begin
              sda_oe <= 1'b1;
              state_q <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            if (phase_q == PH_ADDR && sh_q[`GX_RW_BIT]) begin
              // Read: first byte from the kept command
              tx_q <= tx_byte;
              sda_oe <= ~tx_byte[7];
              ptr_q <= pair_of(tx_idx);
              if (tx_idx == `GX_OFS_IN_LO) begin
                snap_q[7:0] <= pins_s[7:0];
              end else if (tx_idx == `GX_OFS_IN_HI) begin
                snap_q[15:8] <= pins_s[15:8];
              end
              state_q <= ST_TX;
            end else if (phase_q == PH_ADDR) begin
              phase_q <= PH_CMD;
              state_q <= ST_RX;
            end else if (phase_q == PH_CMD) begin
              cmd_q <= sh_q;
              ptr_q <= sh_q;
              phase_q <= PH_DATA;
              state_q <= ST_RX;
            end else begin
              // Input registers and unknown codes drop the data
              if (ptr_q >= `GX_OFS_OUT_LO && ptr_q <= `GX_OFS_TOUT) begin
                rf_q[wr_off[2:0]] <= sh_q;
              end
              ptr_q <= pair_of(ptr_q);
              state_q <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              sda_oe <= 1'b0;
              bit_q <= 4'h0;
              state_q <= ST_MACK;
            end else begin
              sda_oe <= ~tx_q[6];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_q) begin
              tx_q <= tx_byte;
              sda_oe <= ~tx_byte[7];
              ptr_q <= pair_of(tx_idx);
              if (tx_idx == `GX_OFS_IN_LO) begin
                snap_q[7:0] <= pins_s[7:0];
              end else if (tx_idx == `GX_OFS_IN_HI) begin
                snap_q[15:8] <= pins_s[15:8];
              end
              state_q <= ST_TX;
            end else begin
              // Nack ends the read; wait for stop or start
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ****************************************
  // Pins and interrupt
  // ****************************************
  wire [1:0] chg;

  gx_pin_bank #(
    .NPORT(2),
    .PW(8)
  ) u_pins (
    .clk(clk),
    .nrst(nrst),
    .pins_s(pins_s),
    .out_lvl(out_lvl),
    .dir(dir),
    .snap(snap_q),
    .pins_o(port_pins_o),
    .pins_oe(port_pins_oe),
    .chg(chg)
  );

  assign int_n_o = 1'b0;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_n_oe <= 1'b0;
    end else begin
      int_n_oe <= |chg;
    end
  end

endmodule // gx_expander

`default_nettype wire

// ===== include/gx_map.vh
// Constants for the 16-bit serial GPIO expander: register offsets,
// reset values, field positions and timing figures.
// Assumes a single 100 MHz core clock.
`ifndef GX_MAP_VH
`define GX_MAP_VH

// ****************************************
// Register offsets (command byte values)
// ****************************************
`define GX_OFS_IN_LO 8'h00
`define GX_OFS_IN_HI 8'h01
`define GX_OFS_OUT_LO 8'h02
`define GX_OFS_OUT_HI 8'h03
`define GX_OFS_INV_LO 8'h04
`define GX_OFS_INV_HI 8'h05
`define GX_OFS_DIR_LO 8'h06
`define GX_OFS_DIR_HI 8'h07
`define GX_OFS_TOUT 8'h08
`define GX_OFS_RSVD 8'hFF

// ****************************************
// Reset values
// ****************************************
`define GX_RST_OUT 8'hFF
`define GX_RST_INV 8'h00
`define GX_RST_DIR 8'hFF
`define GX_RST_TOUT 8'h01
`define GX_RST_SNAP 16'hFFFF

// ****************************************
// Field positions
// ****************************************
`define GX_TOUT_EN_BIT 0
`define GX_RW_BIT 0
`define GX_STRAP_BUS_BIT 1
`define GX_STRAP_LVL_BIT 0

// ****************************************
// Timing
// ****************************************
`define GX_CLK_PERIOD_NS 10
`define GX_TOUT_US 29000

`endif

// ===== rtl/gx_sync.v
// Two-flop synchroniser for a bundle of slow pin levels.
// Assumes each bit is a level that stays put for many clock cycles.
`timescale 1ns/100ps
`default_nettype none

module gx_sync #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // gx_sync

`default_nettype wire

// ===== rtl/gx_pin_bank.v
// Port pin drivers and per-port change detection.
// Assumes synchronised pin levels and register values from the same clock.
`timescale 1ns/100ps
`default_nettype none

module gx_pin_bank #(
  parameter NPORT = 2,
  parameter PW = 8
) (
  input wire clk,
  input wire nrst,
  input wire [NPORT*PW-1:0] pins_s,
  input wire [NPORT*PW-1:0] out_lvl,
  input wire [NPORT*PW-1:0] dir,
  input wire [NPORT*PW-1:0] snap,
  output reg [NPORT*PW-1:0] pins_o,
  output reg [NPORT*PW-1:0] pins_oe,
  output wire [NPORT-1:0] chg
);

  // ****************************************
  // Drivers
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_o <= {NPORT*PW{1'b1}};
      pins_oe <= {NPORT*PW{1'b0}};
    end else begin
      pins_o <= out_lvl;
      pins_oe <= ~dir;
    end
  end

  // ****************************************
  // Change detection per port
  // ****************************************
  // Only input pins count; flag drops when pin returns to stored level
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      assign chg[g] = |((pins_s[g*PW +: PW] ^ snap[g*PW +: PW])
        & dir[g*PW +: PW]);
    end
  endgenerate

endmodule // gx_pin_bank

`default_nettype wire

// ===== bench/gx_expander_sva.sv
// Checker for the serial GPIO expander, bound to its top module.
// Assumes the bus timeout enable bit stays at its reset value.
`timescale 1ns/100ps
`default_nettype none

module gx_expander_sva #(
  parameter TOUT_CYC = 200,
  parameter TOUT_W = 22
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  input wire logic [15:0] port_pins_i,
  input wire logic [15:0] port_pins_o,
  input wire logic [15:0] port_pins_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  logic [15:0] pins_q;
  logic [15:0] oe_q;
  logic [3:0] quiet_q;
  logic [TOUT_W:0] low_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****************************************
  // Cycles since a pin moved or a pin became input, and since both bus lines were high
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_q <= 16'h0000;
      oe_q <= 16'h0000;
      quiet_q <= 4'h0;
      low_q <= '0;
    end else begin
      pins_q <= port_pins_i;
      oe_q <= port_pins_oe;
      if (port_pins_i != pins_q || |(oe_q & ~port_pins_oe))
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
        quiet_q <= quiet_q + 4'h1;
      if (scl_i && sda_i)
        low_q <= '0;
      else if (!(&low_q))
        low_q <= low_q + 1'b1;
    end
  end

  property p_sda_chg;
    $changed(sda_oe) |-> !scl_i;
  endproperty
  a_sda_chg: assert property (p_sda_chg)
    else $error("data moved in clock high");
  property p_ack_hold;
    $rose(scl_i) && sda_oe |-> sda_oe [*6];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("low bit not held");
  property p_out_commit;
    $changed(port_pins_o) |-> !scl_i;
  endproperty
  a_out_commit: assert property (p_out_commit)
    else $error("late commit");
  property p_dir_commit;
    $changed(port_pins_oe) |-> !scl_i;
  endproperty
  a_dir_commit: assert property (p_dir_commit)
    else $error("dir commit");
  // Pin turned input counts as a cause even if its level never moved
  property p_int_cause;
    $rose(int_n_oe) |-> quiet_q < 4'h8 || |(oe_q & ~port_pins_oe);
  endproperty
  a_int_cause: assert property (p_int_cause)
    else $error("int no cause");
  property p_reset_state;
    $rose(nrst) |-> port_pins_oe == 16'h0000 && port_pins_o == 16'hFFFF
      && !sda_oe && !int_n_oe;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("bad reset");
  property p_timeout;
    low_q > TOUT_CYC + 8 |-> !sda_oe;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("no timeout release");
  property p_open_drain;
    !sda_o && !int_n_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("drives high");

  c_int: cover property ($rose(int_n_oe));
  c_dir: cover property ($changed(port_pins_oe));
  c_ack: cover property ($rose(sda_oe));
endmodule // gx_expander_sva

bind gx_expander gx_expander_sva #(
  .TOUT_CYC(TOUT_CYC),
  .TOUT_W(TOUT_W)
) i_gx_expander_sva (
  .clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_0(addr_strap_0),
  .addr_strap_1(addr_strap_1), .addr_strap_2(addr_strap_2),
  .port_pins_i(port_pins_i), .port_pins_o(port_pins_o),
  .port_pins_oe(port_pins_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe)
);
`default_nettype wire

// ===== bench/gx_bfm.sv
// Two-wire bus master model, one bit every 16 clk cycles.
// Assumes the data line is resolved with a pull-up outside.
`timescale 1ns/100ps
`default_nettype none

module gx_bfm (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ****************************************
  // Bus phases
  // ****************************************
  task automatic q;
    repeat (4) @(posedge clk);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    q();
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
  endtask
  task automatic start;
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
  endtask
  task automatic stop;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(last, r);
  endtask
endmodule // gx_bfm
`default_nettype wire

// ===== bench/tb_gx_expander.sv
// Self-checking bench for the serial GPIO expander.
// Assumes gx_bfm as master and pulled-up pins driven by ext.
`timescale 1ns/100ps
`default_nettype none
`include "gx_map.vh"

module tb_gx_expander;
  localparam logic [7:0] ADR_W = {7'h20, 1'b0};
  localparam logic [7:0] ADR_R = {7'h20, 1'b1};
  logic clk, nrst, scl, m_low, sda_o, sda_oe, int_n_o, int_n_oe;
  logic [15:0] ext, pins_o, pins_oe;
  logic [7:0] rb [0:1];
  logic [7:0] rcmd [0:3] = '{`GX_OFS_OUT_LO, `GX_OFS_INV_LO,
    `GX_OFS_DIR_LO, `GX_OFS_TOUT};
  logic [7:0] rexp [0:3] = '{`GX_RST_OUT, `GX_RST_INV, `GX_RST_DIR,
    `GX_RST_TOUT};
  logic bit_r;
  int compares = 0;
  int miscompares = 0;
  wire sda;
  wire int_l;
  wire [15:0] pins;
  assign sda = ~((sda_oe & ~sda_o) | m_low);
  assign int_l = ~(int_n_oe & ~int_n_o);
  assign pins = (pins_oe & pins_o) | (~pins_oe & ext);

  // Timeout must exceed the longest legal low run of a transfer
  gx_expander #(.TOUT_CYC(1000), .TOUT_W(22)) i_gx_expander (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap_0(2'h0), .addr_strap_1(2'h0),
    .addr_strap_2(2'h0), .port_pins_i(pins), .port_pins_o(pins_o),
    .port_pins_oe(pins_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe)
  );
  gx_bfm i_gx_bfm (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic e = 1'b1);
    logic a;
    i_gx_bfm.wbyte(d, a);
    chk_bit(a, e);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0,
    input logic [7:0] d1);
    i_gx_bfm.start();
    wb(ADR_W);
    wb(cmd);
    wb(d0);
    wb(d1);
    i_gx_bfm.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input logic with_cmd, input int n);
    if (with_cmd) begin
      i_gx_bfm.start();
      wb(ADR_W);
      wb(cmd);
    end
    i_gx_bfm.start();
    wb(ADR_R);
    i_gx_bfm.rbyte(n == 1, rb[0]);
    if (n == 2)
      i_gx_bfm.rbyte(1'b1, rb[1]);
    i_gx_bfm.stop();
  endtask
  task automatic set_pins(input logic [15:0] v);
    @(posedge clk);
    ext <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    ext = 16'hFFFF;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(rcmd[i], 1'b1, 2);
      chk(rb[0], rexp[i]);
      chk(rb[1], rexp[i]);
    end
    chk_bit(int_l, 1'b1);
    wr(`GX_OFS_INV_LO, 8'hF0, 8'h00);
    set_pins(16'h1234);
    chk_bit(int_l, 1'b0);
    rd(`GX_OFS_IN_HI, 1'b1, 1);
    chk(rb[0], 8'h12);
    chk_bit(int_l, 1'b0);
    rd(`GX_OFS_IN_LO, 1'b1, 2);
    chk(rb[0], 8'hC4);
    chk(rb[1], 8'h12);
    chk_bit(int_l, 1'b1);
    set_pins(16'h1235);
    chk_bit(int_l, 1'b0);
    set_pins(16'h1234);
    chk_bit(int_l, 1'b1);
    wr(`GX_OFS_OUT_HI, 8'hA5, 8'h3C);
    wr(`GX_OFS_DIR_LO, 8'h00, 8'h0F);
    repeat (4) @(posedge clk);
    chk(pins_oe, 16'hF0FF);
    chk(pins_o, 16'hA53C);
    chk_bit(int_l, 1'b1);
    rd(`GX_OFS_IN_LO, 1'b1, 2);
    chk(rb[0], 8'h3C);
    chk(rb[1], 8'hA2);
    wr(`GX_OFS_IN_LO, 8'h00, 8'h00);
    rd(`GX_OFS_IN_LO, 1'b1, 1);
    chk(rb[0], 8'h3C);
    wr(`GX_OFS_DIR_LO, 8'hFF, 8'hFF);
    repeat (8) @(posedge clk);
    chk(pins_oe, 16'h0000);
    chk_bit(int_l, 1'b0);
    rd(`GX_OFS_IN_LO, 1'b1, 2);
    chk(rb[0], 8'hC4);
    chk(rb[1], 8'h12);
    chk_bit(int_l, 1'b1);
    rd(`GX_OFS_OUT_HI, 1'b1, 2);
    chk(rb[0], 8'hA5);
    chk(rb[1], 8'h3C);
    i_gx_bfm.start();
    wb({7'h21, 1'b0}, 1'b0);
    wb(`GX_OFS_DIR_LO, 1'b0);
    i_gx_bfm.stop();
    // Stall inside the acknowledge so the timeout must drop the data line
    i_gx_bfm.start();
    for (int i = 7; i >= 0; i--)
      i_gx_bfm.xfer_bit(ADR_W[i], bit_r);
    repeat (20) @(posedge clk);
    chk_bit(sda_oe, 1'b1);
    repeat (1100) @(posedge clk);
    chk_bit(sda_oe, 1'b0);
    wb(`GX_OFS_INV_LO, 1'b0);
    i_gx_bfm.stop();
    rd(8'h00, 1'b0, 1);
    chk(rb[0], 8'hA5);
    stop_test();
  end
endmodule // tb_gx_expander
`default_nettype wire
